// ### hdl/slcr_defines.vh
`ifndef SLCR_DEFINES_VH
`define SLCR_DEFINES_VH

// Register map, byte offsets
`define SLCR_ADDR_W 8
`define SLCR_OFF_NODE 8'h04
`define SLCR_OFF_CTRL 8'h08
`define SLCR_OFF_STAT 8'h0C

// Control register fields
`define SLCR_CTRL_W 9
`define SLCR_CTRL_RST 9'h000
`define SLCR_B_NODE_ID_VALID 0
`define SLCR_B_SIDCAP 1
`define SLCR_B_FBUSY 2
`define SLCR_B_ISOALL 3
`define SLCR_B_CYCCAP 4
`define SLCR_B_ATXEN 5
`define SLCR_B_ARXEN 6
`define SLCR_B_ITXEN 7
`define SLCR_B_IRXEN 8

// Node-address register fields
`define SLCR_NODE_RST 16'h0000
`define SLCR_BUS_MSB 9
`define SLCR_NODE_LSB 10
`define SLCR_NODE_MSB 15
`define SLCR_BCAST_NODE 6'h3F
`define SLCR_LOCAL_BUS 10'h3FF

// Status register fields
`define SLCR_ST_PHASE 4
`define SLCR_ST_BUSY 5
`define SLCR_ST_CODE_MSB 3

// Reset values of datapath registers, and self-ID trailer padding
`define SLCR_WORD_RST 32'h0000_0000
`define SLCR_CODE_RST 4'h0
`define SLCR_TRAILER_PAD 28'h000_0000

// Received packet kinds
`define SLCR_KIND_ASYNC 3'h0
`define SLCR_KIND_ISO 3'h1
`define SLCR_KIND_CYC 3'h2
`define SLCR_KIND_SID 3'h3
`define SLCR_KIND_LINKON 3'h4
`define SLCR_KIND_PHYCFG 3'h5

// Self-ID trailer status codes
`define SLCR_SID_GOOD 4'h1
`define SLCR_SID_BAD 4'hD

`endif

// ### hdl/slcr_rx_filter.v
`timescale 1ns/1ps
`include "slcr_defines.vh"

module slcr_rx_filter (
    input wire [`SLCR_CTRL_W-1:0] ctrl_i,
    input wire [15:0] node_addr_i,
    input wire [2:0] kind_i,
    input wire [15:0] dest_i,
    input wire chan_match_i,
    input wire fifo_full_i,
    output reg accept_o,
    output reg busy_o
);
    reg bcast;
    reg bus_ok;
    reg mine;
    always @* begin
        bcast = (dest_i[`SLCR_NODE_MSB:`SLCR_NODE_LSB] == `SLCR_BCAST_NODE);
        bus_ok = (dest_i[`SLCR_BUS_MSB:0] == `SLCR_LOCAL_BUS) ||
                 (dest_i[`SLCR_BUS_MSB:0] == node_addr_i[`SLCR_BUS_MSB:0]);
        mine = bus_ok && ctrl_i[`SLCR_B_NODE_ID_VALID] && (dest_i[`SLCR_NODE_MSB:`SLCR_NODE_LSB] ==
               node_addr_i[`SLCR_NODE_MSB:`SLCR_NODE_LSB]);
        accept_o = 1'b0;
        busy_o = 1'b0;
        case (kind_i)
            `SLCR_KIND_ASYNC: begin
                accept_o = ctrl_i[`SLCR_B_ARXEN] && ((bcast && bus_ok) || mine);
                busy_o = ctrl_i[`SLCR_B_ARXEN] && mine && !bcast &&
                         (ctrl_i[`SLCR_B_FBUSY] || fifo_full_i);
            end
            `SLCR_KIND_ISO: begin
                accept_o = ctrl_i[`SLCR_B_IRXEN] &&
                           (ctrl_i[`SLCR_B_ISOALL] || chan_match_i);
            end
            `SLCR_KIND_CYC: begin
                accept_o = ctrl_i[`SLCR_B_CYCCAP];
            end
            `SLCR_KIND_LINKON, `SLCR_KIND_PHYCFG: begin
                accept_o = ctrl_i[`SLCR_B_SIDCAP];
            end
            default: begin
                accept_o = 1'b0;
            end
        endcase
    end
endmodule

// ### hdl/slcr_sid_check.v
`timescale 1ns/1ps
`include "slcr_defines.vh"

module slcr_sid_check (
    input wire sys_clk_i,
    input wire rst_i,
    input wire clr_i,
    input wire q_valid_i,
    input wire [31:0] q_i,
    output wire [3:0] status_o
);
    reg [31:0] first_r;
    reg second_r;
    reg err_r;
    // A trailing unpaired quadlet also marks the capture as bad
    assign status_o = (err_r || second_r) ? `SLCR_SID_BAD : `SLCR_SID_GOOD;
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            first_r <= 32'h0000_0000;
            second_r <= 1'b0;
            err_r <= 1'b0;
        end else if (clr_i) begin
            first_r <= 32'h0000_0000;
            second_r <= 1'b0;
            err_r <= 1'b0;
        end else if (q_valid_i) begin
            second_r <= !second_r;
            if (!second_r) begin
                first_r <= q_i;
            end else if (q_i != ~first_r) begin
                err_r <= 1'b1;
            end
        end
    end
endmodule

// ### hdl/slcr_link_ctrl.v
// Contract
// - Control register at 08h, read/write, all zeros after reset.
// - With node ID valid, accept packets addressed to our node number.
// - With node ID invalid, accept broadcast packets only.
// - Self-ID capture stores the self-ID packets as one combined packet.
// - Each self-ID packet is two quadlets, second the inverse of first.
// - Combined self-ID status code is 1h when good, Dh when wrong.
// - Self-ID capture also stores link-on and PHY configuration packets.
// - Only the first quadlet of link-on or PHY configuration is stored.
// - Forced busy answers every non-broadcast async packet with ack_busy_x; the code does so only for packets to our node with async receive enabled.
// - Without forced busy, ack_busy_x only when the receive FIFO is full.
// - Receive-all with iso receive enable takes every iso channel.
// - Cycle-start capture stores each received cycle-start packet.
// - Async transmit disabled: no arbitration and no async sends.
// - Bus reset clears the async transmit enable.
// - Async receive disabled: no async packets are accepted.
// - Bus reset clears the async receive enable.
// - Iso transmit disabled: no arbitration for iso packets.
// - Iso receive disabled: no iso packets are accepted.
// - After bus reset the node number loads from the PHY identifier.
`timescale 1ns/1ps
`include "slcr_defines.vh"

module slcr_link_ctrl (
    input wire sys_clk_i,
    input wire rst_i,
    input wire [`SLCR_ADDR_W-1:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output wire [31:0] reg_rdata_o,
    input wire bus_reset_i,
    input wire phy_id_valid_i,
    input wire [5:0] phy_id_i,
    input wire selfid_done_i,
    input wire rx_hdr_valid_i,
    input wire [2:0] rx_kind_i,
    input wire [15:0] rx_dest_i,
    input wire rx_chan_match_i,
    input wire rx_quad_valid_i,
    input wire [31:0] rx_quad_i,
    input wire rx_pkt_end_i,
    input wire fifo_full_i,
    output wire fifo_wr_o,
    output wire [31:0] fifo_data_o,
    output wire rx_store_o,
    output wire ack_busy_o,
    output wire tx_async_arb_o,
    output wire tx_iso_arb_o,
    output wire [15:0] node_addr_o
);
    // Receive states, one-hot
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_SID = 5'h02;
    localparam [4:0] ST_PHYQ = 5'h04;
    localparam [4:0] ST_PASS = 5'h08;
    localparam [4:0] ST_DROP = 5'h10;

    reg [`SLCR_CTRL_W-1:0] ctrl_r;
    reg [`SLCR_CTRL_W-1:0] ctrl_nxt;
    reg [15:0] node_r;
    reg [15:0] node_nxt;
    reg [31:0] rdata_r;
    reg [31:0] rdata_nxt;
    reg [4:0] state_r;
    reg [4:0] state_nxt;
    reg fifo_wr_r;
    reg fifo_wr_nxt;
    reg [31:0] fifo_data_r;
    reg [31:0] fifo_data_nxt;
    reg store_r;
    reg store_nxt;
    reg busy_r;
    reg busy_nxt;
    reg last_busy_r;
    reg last_busy_nxt;
    reg [3:0] sid_stat_r;
    reg [3:0] sid_stat_nxt;
    reg [31:0] stat_word;
    reg sid_clr;

    wire flt_accept;
    wire flt_busy;
    wire [3:0] chk_status;
    wire sel_node;
    wire sel_ctrl;
    wire sid_q;
    wire rx_idle;
    wire hdr_take;
    wire first_only;
    wire [31:0] sid_trailer;

    assign sel_node = (reg_addr_i == `SLCR_OFF_NODE);
    assign sel_ctrl = (reg_addr_i == `SLCR_OFF_CTRL);
    assign sid_q = (state_r == ST_SID) && rx_quad_valid_i;
    assign rx_idle = (state_r == ST_IDLE);
    // Headers count only while idle and not swallowed by a bus reset
    assign hdr_take = rx_hdr_valid_i && rx_idle && !bus_reset_i;
    assign first_only = (rx_kind_i == `SLCR_KIND_LINKON) || (rx_kind_i == `SLCR_KIND_PHYCFG);
    assign sid_trailer = {`SLCR_TRAILER_PAD, chk_status};

    assign reg_rdata_o = rdata_r;
    assign fifo_wr_o = fifo_wr_r;
    assign fifo_data_o = fifo_data_r;
    assign rx_store_o = store_r;
    assign ack_busy_o = busy_r;
    assign tx_async_arb_o = ctrl_r[`SLCR_B_ATXEN];
    assign tx_iso_arb_o = ctrl_r[`SLCR_B_ITXEN];
    assign node_addr_o = node_r;

    slcr_rx_filter u_filter (
        .ctrl_i(ctrl_r),
        .node_addr_i(node_r),
        .kind_i(rx_kind_i),
        .dest_i(rx_dest_i),
        .chan_match_i(rx_chan_match_i),
        .fifo_full_i(fifo_full_i),
        .accept_o(flt_accept),
        .busy_o(flt_busy)
    );

    slcr_sid_check u_sid (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .clr_i(sid_clr),
        .q_valid_i(sid_q),
        .q_i(rx_quad_i),
        .status_o(chk_status)
    );

    // Control register; a bus reset clears the async enables over a same-cycle software write
    always @* begin
        ctrl_nxt = ctrl_r;
        if (reg_wr_i && sel_ctrl) begin
            ctrl_nxt = reg_wdata_i[`SLCR_CTRL_W-1:0];
        end
        if (bus_reset_i) begin
            ctrl_nxt[`SLCR_B_ATXEN] = 1'b0;
            ctrl_nxt[`SLCR_B_ARXEN] = 1'b0;
        end
    end

    // Node address; the PHY identifier load wins over a software write
    always @* begin
        node_nxt = node_r;
        if (reg_wr_i && sel_node) begin
            node_nxt = reg_wdata_i[15:0];
        end
        if (phy_id_valid_i) begin
            node_nxt[`SLCR_NODE_MSB:`SLCR_NODE_LSB] = phy_id_i;
        end
    end

    // Status word: last self-ID code, self-ID phase, last header busy
    always @* begin
        stat_word = `SLCR_WORD_RST;
        stat_word[`SLCR_ST_CODE_MSB:0] = sid_stat_r;
        stat_word[`SLCR_ST_PHASE] = (state_r == ST_SID);
        stat_word[`SLCR_ST_BUSY] = last_busy_r;
    end

    // Read data exists only in the cycle after the read strobe
    always @* begin
        rdata_nxt = `SLCR_WORD_RST;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `SLCR_OFF_CTRL: begin
                    rdata_nxt[`SLCR_CTRL_W-1:0] = ctrl_r;
                end
                `SLCR_OFF_NODE: begin
                    rdata_nxt[`SLCR_NODE_MSB:0] = node_r;
                end
                `SLCR_OFF_STAT: begin
                    rdata_nxt = stat_word;
                end
                default: begin
                    rdata_nxt = `SLCR_WORD_RST;
                end
            endcase
        end
    end

    // Receive path sequencing
    always @* begin
        state_nxt = state_r;
        fifo_wr_nxt = 1'b0;
        fifo_data_nxt = fifo_data_r;
        store_nxt = 1'b0;
        busy_nxt = 1'b0;
        sid_stat_nxt = sid_stat_r;
        sid_clr = 1'b0;
        if (bus_reset_i) begin
            sid_clr = 1'b1;
            if (ctrl_r[`SLCR_B_SIDCAP]) begin
                state_nxt = ST_SID;
            end else begin
                state_nxt = ST_IDLE;
            end
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (rx_hdr_valid_i) begin
                        busy_nxt = flt_busy;
                        store_nxt = flt_accept && !flt_busy;
                        if (!flt_accept || flt_busy) begin
                            state_nxt = ST_DROP;
                        end else if (first_only) begin
                            state_nxt = ST_PHYQ;
                        end else begin
                            state_nxt = ST_PASS;
                        end
                    end
                end
                ST_SID: begin
                    if (rx_quad_valid_i) begin
                        fifo_wr_nxt = 1'b1;
                        fifo_data_nxt = rx_quad_i;
                    end
                    if (selfid_done_i) begin
                        fifo_wr_nxt = 1'b1;
                        fifo_data_nxt = sid_trailer;
                        sid_stat_nxt = chk_status;
                        state_nxt = ST_IDLE;
                    end
                end
                ST_PHYQ: begin
                    if (rx_quad_valid_i) begin
                        fifo_wr_nxt = 1'b1;
                        fifo_data_nxt = rx_quad_i;
                        state_nxt = rx_pkt_end_i ? ST_IDLE : ST_DROP;
                    end else if (rx_pkt_end_i) begin
                        state_nxt = ST_IDLE;
                    end
                end
                ST_PASS: begin
                    if (rx_quad_valid_i) begin
                        fifo_wr_nxt = 1'b1;
                        fifo_data_nxt = rx_quad_i;
                    end
                    if (rx_pkt_end_i) begin
                        state_nxt = ST_IDLE;
                    end
                end
                ST_DROP: begin
                    if (rx_pkt_end_i) begin
                        state_nxt = ST_IDLE;
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // Status busy flag follows the answer to the last header taken
    always @* begin
        last_busy_nxt = last_busy_r;
        if (hdr_take) begin
            last_busy_nxt = busy_nxt;
        end
    end

    // Software-written registers
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r <= `SLCR_CTRL_RST;
            node_r <= `SLCR_NODE_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            node_r <= node_nxt;
        end
    end

    // Read data and status
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= `SLCR_WORD_RST;
            last_busy_r <= 1'b0;
            sid_stat_r <= `SLCR_CODE_RST;
        end else begin
            rdata_r <= rdata_nxt;
            last_busy_r <= last_busy_nxt;
            sid_stat_r <= sid_stat_nxt;
        end
    end

    // Receive path
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            fifo_wr_r <= 1'b0;
            fifo_data_r <= `SLCR_WORD_RST;
            store_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            fifo_wr_r <= fifo_wr_nxt;
            fifo_data_r <= fifo_data_nxt;
            store_r <= store_nxt;
            busy_r <= busy_nxt;
        end
    end
endmodule

// ### test/slcr_link_ctrl_checker.sv
`timescale 1ns/1ps
module slcr_link_ctrl_checker (
    input wire sys_clk_i,
    input wire rst_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [31:0] reg_rdata_o,
    input wire bus_reset_i,
    input wire phy_id_valid_i,
    input wire [5:0] phy_id_i,
    input wire selfid_done_i,
    input wire rx_hdr_valid_i,
    input wire [2:0] rx_kind_i,
    input wire [15:0] rx_dest_i,
    input wire rx_quad_valid_i,
    input wire [31:0] rx_quad_i,
    input wire fifo_wr_o,
    input wire [31:0] fifo_data_o,
    input wire rx_store_o,
    input wire ack_busy_o,
    input wire tx_async_arb_o,
    input wire tx_iso_arb_o,
    input wire [15:0] node_addr_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside read slot");
    a_atx_write: assert property (reg_wr_i && reg_addr_i == 8'h08 && !bus_reset_i
        |=> tx_async_arb_o == $past(reg_wdata_i[5])) else $error("async tx gate wrong");
    a_itx_write: assert property (reg_wr_i && reg_addr_i == 8'h08
        |=> tx_iso_arb_o == $past(reg_wdata_i[7])) else $error("iso tx gate wrong");
    a_busrst_atx: assert property (bus_reset_i |=> !tx_async_arb_o)
        else $error("bus reset kept async tx");
    a_atx_hold: assert property (!reg_wr_i && !bus_reset_i |=> $stable(tx_async_arb_o))
        else $error("async tx gate moved");
    a_busy_cause: assert property (ack_busy_o |-> $past(rx_hdr_valid_i) &&
        $past(rx_kind_i) == 3'h0 && $past(rx_dest_i[15:10]) != 6'h3F)
        else $error("busy ack without own async header");
    a_busy_nostore: assert property (ack_busy_o |-> !rx_store_o)
        else $error("busy packet stored");
    a_store_hdr: assert property (rx_store_o |-> $past(rx_hdr_valid_i))
        else $error("store without header");
    a_fifo_src: assert property (fifo_wr_o |->
        $past(rx_quad_valid_i) || $past(selfid_done_i)) else $error("fifo write without source");
    a_fifo_data: assert property (fifo_wr_o && !$past(selfid_done_i)
        |-> fifo_data_o == $past(rx_quad_i)) else $error("fifo word differs");
    a_node_load: assert property (phy_id_valid_i |=>
        node_addr_o[15:10] == $past(phy_id_i)) else $error("node number not loaded");
endmodule
bind slcr_link_ctrl slcr_link_ctrl_checker u_chk (.sys_clk_i, .rst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bus_reset_i, .phy_id_valid_i,
    .phy_id_i, .selfid_done_i, .rx_hdr_valid_i, .rx_kind_i, .rx_dest_i, .rx_quad_valid_i,
    .rx_quad_i, .fifo_wr_o, .fifo_data_o, .rx_store_o, .ack_busy_o, .tx_async_arb_o,
    .tx_iso_arb_o, .node_addr_o);

// ### test/slcr_phy_model.sv
`timescale 1ns/1ps
module slcr_phy_model (
    input wire sys_clk_i,
    output logic bus_reset_o = 1'b0,
    output logic id_valid_o = 1'b0,
    output logic [5:0] id_o = 6'h0,
    output logic sid_done_o = 1'b0,
    output logic hdr_o = 1'b0,
    output logic [2:0] kind_o = 3'h0,
    output logic [15:0] dest_o = 16'h0,
    output logic chan_o = 1'b0,
    output logic qv_o = 1'b0,
    output logic [31:0] q_o = 32'h0,
    output logic end_o = 1'b0
);
    task automatic brst();
        @(posedge sys_clk_i) bus_reset_o <= 1'b1;
        @(posedge sys_clk_i) bus_reset_o <= 1'b0;
    endtask
    task automatic load_id(input logic [5:0] v);
        @(posedge sys_clk_i) id_valid_o <= 1'b1;
        id_o <= v;
        @(posedge sys_clk_i) id_valid_o <= 1'b0;
        id_o <= ~v;
    endtask
    task automatic sid_end();
        @(posedge sys_clk_i) sid_done_o <= 1'b1;
        @(posedge sys_clk_i) sid_done_o <= 1'b0;
    endtask
    // Released destination and quadlet lines show the inverse of their last value; kind and channel hold theirs
    task automatic send(input bit h, input logic [2:0] k, input logic [15:0] d, input bit c,
                        input int n, input logic [31:0] q, input bit bad);
        @(posedge sys_clk_i) hdr_o <= h;
        kind_o <= k;
        dest_o <= d;
        chan_o <= c;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk_i) hdr_o <= 1'b0;
            dest_o <= ~d;
            qv_o <= 1'b1;
            q_o <= (i % 2) ? (~q ^ {31'h0, bad}) : q;
        end
        @(posedge sys_clk_i) hdr_o <= 1'b0;
        qv_o <= 1'b0;
        q_o <= ~q_o;
        end_o <= 1'b1;
        @(posedge sys_clk_i) end_o <= 1'b0;
    endtask
endmodule

// ### test/slcr_link_ctrl_tb.sv
`timescale 1ns/1ps
module slcr_link_ctrl_tb;
    logic sys_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, fifo_full_i = 0;
    logic [7:0] reg_addr_i = 0;
    logic [31:0] reg_wdata_i = 0, w;
    wire [31:0] reg_rdata_o, fifo_data_o, rx_quad_i;
    wire [15:0] node_addr_o, rx_dest_i;
    wire [5:0] phy_id_i;
    wire [2:0] rx_kind_i;
    wire fifo_wr_o, rx_store_o, ack_busy_o, tx_async_arb_o, tx_iso_arb_o, bus_reset_i;
    wire phy_id_valid_i, selfid_done_i, rx_hdr_valid_i, rx_chan_match_i, rx_quad_valid_i;
    wire rx_pkt_end_i;
    int failures = 0, compares = 0, seed = 32'hC6D4;
    logic [31:0] rq[$], fq[$];
    logic [1:0] pq[$];
    logic rd_d = 0, hv_d = 0;
    logic [2:0] k;
    logic [11:0] c;
    logic [15:0] d;
    logic [3:0] f;
    // Entry: kind, control, destination, {chan match, fifo full, busy, store}
    logic [34:0] tbl [13] = '{{3'h0, 12'h041, 16'h17FF, 4'h1}, {3'h0, 12'h040, 16'h17FF, 4'h0},
        {3'h0, 12'h040, 16'hFFFF, 4'h1}, {3'h0, 12'h041, 16'h1BFF, 4'h0},
        {3'h0, 12'h001, 16'h17FF, 4'h0}, {3'h0, 12'h045, 16'h17FF, 4'h2},
        {3'h0, 12'h045, 16'hFFFF, 4'h1}, {3'h0, 12'h041, 16'h17FF, 4'h6},
        {3'h1, 12'h108, 16'h17FF, 4'h1}, {3'h1, 12'h008, 16'h17FF, 4'h8},
        {3'h1, 12'h100, 16'h17FF, 4'h0}, {3'h2, 12'h010, 16'h17FF, 4'h1},
        {3'h2, 12'h000, 16'h17FF, 4'h0}};
    slcr_link_ctrl dut (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .bus_reset_i, .phy_id_valid_i, .phy_id_i, .selfid_done_i,
        .rx_hdr_valid_i, .rx_kind_i, .rx_dest_i, .rx_chan_match_i, .rx_quad_valid_i,
        .rx_quad_i, .rx_pkt_end_i, .fifo_full_i, .fifo_wr_o, .fifo_data_o, .rx_store_o,
        .ack_busy_o, .tx_async_arb_o, .tx_iso_arb_o, .node_addr_o);
    slcr_phy_model u_phy (.sys_clk_i, .bus_reset_o(bus_reset_i), .id_valid_o(phy_id_valid_i),
        .id_o(phy_id_i), .sid_done_o(selfid_done_i), .hdr_o(rx_hdr_valid_i),
        .kind_o(rx_kind_i), .dest_o(rx_dest_i), .chan_o(rx_chan_match_i),
        .qv_o(rx_quad_valid_i), .q_o(rx_quad_i), .end_o(rx_pkt_end_i));
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_i) reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge sys_clk_i) reg_wr_i <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_i) reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        rq.push_back(v);
        @(posedge sys_clk_i) reg_rd_i <= 1'b0;
    endtask
    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        rd_d <= reg_rd_i;
        hv_d <= rx_hdr_valid_i;
        if (rd_d) check("rdata", reg_rdata_o, rq.pop_front());
        if (hv_d) check("flags", {ack_busy_o, rx_store_o}, pq.pop_front());
        if (fifo_wr_o) begin
            check("fifo_extra", fq.size() != 0, 1);
            if (fq.size() != 0) check("fifo", fifo_data_o, fq.pop_front());
        end
    end
    initial begin
        #80000;
        failures++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rdr(8'h08, 0);
        rdr(8'h04, 0);
        wrr(8'h10, 32'hFFFFFFFF);
        rdr(8'h10, 0);
        for (int i = 0; i < 4; i++) begin
            w = $random(seed);
            wrr(8'h08, w);
            rdr(8'h08, w & 32'h1FF);
        end
        $display("test registers done");
        wrr(8'h08, 32'h1FD);
        u_phy.brst();
        rdr(8'h08, 32'h19D);
        u_phy.load_id(6'h2A);
        rdr(8'h04, 32'hA800);
        $display("test bus_reset done");
        wrr(8'h04, 32'h17FF);
        foreach (tbl[i]) begin
            {k, c, d, f} = tbl[i];
            wrr(8'h08, {20'h0, c});
            fifo_full_i <= f[2];
            pq.push_back(f[1:0]);
            w = $random(seed);
            if (f[0]) fq.push_back(w);
            u_phy.send(1, k, d, f[3], 1, w, 0);
        end
        fifo_full_i <= 1'b0;
        $display("test receive done");
        for (int b = 0; b < 2; b++) begin
            wrr(8'h08, 32'h002);
            u_phy.brst();
            w = $random(seed);
            fq.push_back(w);
            fq.push_back(~w ^ b);
            fq.push_back(b ? 32'hD : 32'h1);
            u_phy.send(0, 3'h3, 16'h0, 0, 2, w, b);
            u_phy.sid_end();
        end
        rdr(8'h0C, 32'hD);
        for (int j = 4; j < 6; j++) begin
            pq.push_back(2'b01);
            w = $random(seed);
            fq.push_back(w);
            u_phy.send(1, j[2:0], 16'hFFFF, 0, 2, w, 0);
        end
        $display("test selfid done");
        repeat (4) @(posedge sys_clk_i);
        wrap_up();
    end
endmodule
